// *** core/pch_config_header.sv ***
// Configuration header for both functions of the dual-channel controller.
// Assumes the bus front end decodes config cycles into one-cycle strobes
// and reports bus events per function as one-cycle pulses.
`timescale 1ns/1ns
module pch_config_header
  import pch_pkg::*;
#(
  parameter logic [15:0] MAKER_ID   = 16'h5A5A, // Arbitrary value
  parameter logic [15:0] PART_ID    = 16'h0C3C, // Arbitrary value
  parameter logic [7:0]  REVISION   = 8'h01,    // Arbitrary value
  parameter logic [15:0] BOARD_MAKR = 16'h0000, // Arbitrary value
  parameter logic [15:0] BOARD_ID   = 16'h0000, // Arbitrary value
  parameter logic [7:0]  MAX_LAT    = 8'h00,
  parameter logic [7:0]  PWR_CAP_ID = 8'h01,
  parameter logic [15:0] PWR_CAPS   = 16'h0000,
  parameter logic [31:0] ROM_RO     = 32'h00007FFE  // 32 Kbyte window by default
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Configuration access port
  input  wire logic        i_cfg_sel,
  input  wire logic        i_cfg_rd,
  input  wire logic        i_cfg_wr,
  input  wire logic [10:0] i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_ack,
  // Power-up strap and per-function chip test enable
  input  wire logic        i_int_strap,
  input  wire logic [1:0]  i_chip_test_inv_en,
  // Bus events per function
  input  wire logic [1:0]  i_data_parity_err,
  input  wire logic [1:0]  i_addr_parity_err,
  input  wire logic [1:0]  i_sys_err_req,
  input  wire logic [1:0]  i_master_perr,
  input  wire logic [1:0]  i_master_abort,
  input  wire logic [1:0]  i_special_cycle,
  input  wire logic [1:0]  i_target_abort,
  // Enables presented to the rest of the chip
  output logic [1:0]       o_io_claim_en,
  output logic [1:0]       o_mem_claim_en,
  output logic [1:0]       o_master_en,
  output logic [1:0]       o_parity_check_en,
  output logic [1:0]       o_mwi_allowed,
  output logic [1:0]       o_perf_cmd_ok,
  output logic [1:0]       o_serr_oe,
  output logic             o_func_b_on_line_a,
  output logic [15:0]      o_latency_limit,
  output logic [15:0]      o_cache_line
);

  // True when the value has exactly one bit set
  function automatic logic is_pow2(input logic [7:0] v);
    is_pow2 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  // Merge write data into a register under byte enables and a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    merge = (old & ~m) | (wd & m);
  endfunction

  // Per-function storage, indexed by function number
  logic [15:0] command     [2];  // Access enables
  logic [15:0] status_flag [2];  // Sticky error bits only
  logic [7:0]  cache_line  [2];  // Line size in words
  logic [7:0]  lat_limit   [2];  // Master latency in clocks
  logic [31:0] bar_io      [2];  // I/O window
  logic [31:0] bar_mem_lo  [2];  // Memory window low
  logic [31:0] bar_mem_hi  [2];  // Memory window high
  logic [31:0] bar_ram_lo  [2];  // Script RAM low
  logic [31:0] bar_ram_hi  [2];  // Script RAM high
  logic [31:0] rom_base    [2];  // Option ROM base and enable
  logic        strap_q;          // Routing strap caught during reset

  // Access decode
  wire logic [2:0] acc_func = i_cfg_addr[10:8];                   // see [RQ1]
  wire logic [7:0] acc_ofs  = {i_cfg_addr[7:2], 2'b00};
  wire logic       func_ok  = (acc_func == FUNC_A) || (acc_func == FUNC_B);
  wire logic       acc_idx  = (acc_func == FUNC_B);
  wire logic       do_wr    = i_cfg_sel && i_cfg_wr && func_ok;
  wire logic       do_rd    = i_cfg_sel && i_cfg_rd && func_ok;

  // Strap is sampled while reset is held, so it is stable after release
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strap_q <= i_int_strap;
    end
  end

  // Interrupt pin value of the selected function
  wire logic [7:0] pin_b   = strap_q ? PIN_A : PIN_B;             // see [RQ23]
  wire logic [7:0] acc_pin = acc_idx ? pin_b : PIN_A;

  // Status word: sticky flags plus fixed fields
  wire logic [15:0] st_read = (status_flag[acc_idx] & ST_STICKY) | ST_FIXED; // see [RQ17] [RQ19]

  // Read mux; any location not listed reads zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (acc_ofs)
      OFS_ID:      rd_mux = {PART_ID, MAKER_ID};                  // see [RQ3] [RQ4]
      OFS_CMDSTAT: rd_mux = {st_read, command[acc_idx]};          // see [RQ12]
      OFS_CLASS:   rd_mux = {CLASS_CODE, REVISION};               // see [RQ20]
      OFS_LN_LAT:  rd_mux = {8'h00, HDR_TYPE, lat_limit[acc_idx], cache_line[acc_idx]};
      OFS_IO_BASE: rd_mux = bar_io[acc_idx];
      OFS_MEM_LO:  rd_mux = bar_mem_lo[acc_idx];
      OFS_MEM_HI:  rd_mux = bar_mem_hi[acc_idx];
      OFS_RAM_LO:  rd_mux = bar_ram_lo[acc_idx];
      OFS_RAM_HI:  rd_mux = bar_ram_hi[acc_idx];
      OFS_SUBSYS:  rd_mux = {BOARD_ID, BOARD_MAKR};
      OFS_ROM:     rd_mux = rom_base[acc_idx];
      OFS_CAPPTR:  rd_mux = {24'h000000, CAP_PTR};
      OFS_INTLAT:  rd_mux = {MAX_LAT, 8'h00, acc_pin, 8'h00};
      OFS_PWRCAP:  rd_mux = {PWR_CAPS, 8'h00, PWR_CAP_ID};
      default:     rd_mux = 32'h00000000;                         // see [RQ2]
    endcase
  end

  // Read answer registered, ack one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cfg_rdata <= 32'h00000000;
      o_cfg_ack   <= 1'b0;
    end else begin
      o_cfg_ack   <= do_rd || do_wr;
      if (do_rd) begin
        o_cfg_rdata <= rd_mux;
      end
    end
  end

  // Per-function logic
  for (genvar f = 0; f < 2; f++) begin : g_func
    // Write strobe aimed at this function only
    wire logic wr_here   = do_wr && (acc_idx == 1'(f));
    // Command bits used by the error and parity paths
    wire logic serr_en   = command[f][CMD_SERR];
    wire logic perr_resp = command[f][CMD_PARITY];

    // Error driver: system error needs its enable, address parity also parity enable.
    // Address parity alone never drives the pin, so a host that only set the
    // error enable still sees system errors but no address parity reports.
    wire logic serr_now  = serr_en &&
                           (i_sys_err_req[f] || (perr_resp && i_addr_parity_err[f])); // see [RQ6]

    // Command write merged as a full word so the mask is applied in one place
    wire logic [31:0] cmd_wide = merge({16'h0000, command[f]}, i_cfg_wdata, i_cfg_be,
                                       {16'h0000, CMD_MASK});
    // Events that set sticky flags this cycle
    wire logic [15:0] st_set = {i_data_parity_err[f],                           // see [RQ13]
                                o_serr_oe[f],                                   // see [RQ14]
                                i_master_abort[f] && !i_special_cycle[f],       // see [RQ15]
                                i_target_abort[f],                              // see [RQ16]
                                3'b000,
                                i_master_perr[f] && perr_resp,                  // see [RQ18]
                                8'h00};
    // Write-one-clear mask of the status half, only when byte lanes enabled
    wire logic [15:0] st_clr = (wr_here && acc_ofs == OFS_CMDSTAT) ?
                               ({{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}} & i_cfg_wdata[31:16]) :
                               16'h0000;

    // Error driver enable is a one-cycle pulse per request
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        o_serr_oe[f] <= 1'b0;
      end else begin
        o_serr_oe[f] <= serr_now;
      end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        status_flag[f] <= 16'h0000;
      end else begin
        status_flag[f] <= ((status_flag[f] & ~st_clr) | st_set) & ST_STICKY; // see [RQ12] [RQ25]
      end
    end

    // Command and line size / latency registers
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        command[f]    <= CMD_RESET;                               // see [RQ5]
        cache_line[f] <= 8'h00;
        lat_limit[f]  <= 8'h00;                                   // see [RQ24]
      end else if (wr_here && acc_ofs == OFS_CMDSTAT) begin
        // Reserved command bits stay zero whatever the host writes
        command[f]    <= cmd_wide[15:0];                          // see [RQ25]
      end else if (wr_here && acc_ofs == OFS_LN_LAT) begin
        // Each byte lane updates on its own enable
        cache_line[f] <= i_cfg_be[0] ? i_cfg_wdata[7:0] : cache_line[f];
        lat_limit[f]  <= i_cfg_be[1] ? i_cfg_wdata[15:8] : lat_limit[f]; // see [RQ24]
      end
    end

    // Base registers; low bits fixed per window size
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        bar_io[f]     <= IO_LOW_FIX;
        bar_mem_lo[f] <= BARM_FIX;
        bar_mem_hi[f] <= 32'h00000000;
        bar_ram_lo[f] <= BARM_FIX;
        bar_ram_hi[f] <= 32'h00000000;
        rom_base[f]   <= 32'h00000000;
      end else if (wr_here) begin
        // Low bits are hardwired, so a write of all ones reads back the window size
        if (acc_ofs == OFS_IO_BASE) begin
          bar_io[f] <= merge(bar_io[f], i_cfg_wdata, i_cfg_be, ~IO_LOW_RO) | IO_LOW_FIX;
        end
        // Memory window, lower half
        if (acc_ofs == OFS_MEM_LO) begin
          bar_mem_lo[f] <= merge(bar_mem_lo[f], i_cfg_wdata, i_cfg_be, ~MEM_LOW_RO) | BARM_FIX;
        end
        // Memory window, upper half is fully writable
        if (acc_ofs == OFS_MEM_HI) begin
          bar_mem_hi[f] <= merge(bar_mem_hi[f], i_cfg_wdata, i_cfg_be, 32'hFFFFFFFF);
        end
        // Script RAM window, lower half
        if (acc_ofs == OFS_RAM_LO) begin
          bar_ram_lo[f] <= merge(bar_ram_lo[f], i_cfg_wdata, i_cfg_be, ~RAM_LOW_RO) | BARM_FIX;
        end
        // Script RAM window, upper half is fully writable
        if (acc_ofs == OFS_RAM_HI) begin
          bar_ram_hi[f] <= merge(bar_ram_hi[f], i_cfg_wdata, i_cfg_be, 32'hFFFFFFFF);
        end
        if (acc_ofs == OFS_ROM) begin
          rom_base[f] <= merge(rom_base[f], i_cfg_wdata, i_cfg_be, ~ROM_RO | ROM_EN);
        end
      end
    end

    // Enables out to the bus engines
    assign o_io_claim_en[f]     = command[f][CMD_IO];             // see [RQ11]
    assign o_mem_claim_en[f]    = command[f][CMD_MEM];            // see [RQ10]
    assign o_master_en[f]       = command[f][CMD_MASTER];         // see [RQ9] [RQ5]
    // Parity generation is never gated; only checking follows this bit
    assign o_parity_check_en[f] = perr_resp;                      // see [RQ7]
    // Performance commands only for a power-of-two line size
    assign o_perf_cmd_ok[f]     = is_pow2(cache_line[f]);         // see [RQ21] [RQ22]
    assign o_mwi_allowed[f]     = command[f][CMD_INVW] && i_chip_test_inv_en[f] &&
                                  command[f][CMD_MASTER] && is_pow2(cache_line[f]); // see [RQ8]
    assign o_latency_limit[f*8 +: 8] = lat_limit[f];
    assign o_cache_line[f*8 +: 8]    = cache_line[f];
  end

  // Second function routes to the first interrupt line under the strap
  assign o_func_b_on_line_a = strap_q;                            // see [RQ23]

endmodule // pch_config_header

// *** core/pch_pkg.sv ***
// Constants for the dual-function configuration header block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
// Summary of operation
// [RQ1] Address bits 10:8 pick function zero or one
// [RQ2] Unimplemented locations ignore writes, read zero
// [RQ3] Read-only 16-bit maker code at offset zero
// [RQ4] Read-only 16-bit part code at offset two
// [RQ5] Zero command: configuration access only, no mastering
// [RQ6] Error driver needs bit 8; address parity needs 6
// [RQ7] Bit 6 enables data parity checks; parity always generated
// [RQ8] Invalidate writes need bit 4 and chip test enable
// [RQ9] Master enable clear blocks all master transactions
// [RQ10] Memory windows claimed only with memory enable
// [RQ11] I/O window claimed only with I/O enable
// [RQ12] Status writes clear ones, never set bits
// [RQ13] Bit 15 set on any detected data parity error
// [RQ14] Bit 14 set whenever error signal is driven
// [RQ15] Bit 13 set on non-special master abort
// [RQ16] Bit 12 set on received target abort
// [RQ17] Target select timing reads medium, 0b01
// [RQ18] Bit 8 set: master, parity error, response enabled
// [RQ19] Bits 7,5 read zero; bit 4 reads one
// [RQ20] Class reads 0x010000; revision field read-only
// [RQ21] Cache line size picks master command flavours
// [RQ22] Non-power-of-two line size: basic commands only
// [RQ23] Second function pin 0x02, strap gives 0x01
// [RQ24] Latency timer: eight writable bits, resets zero
// [RQ25] Reserved bits read zero, ignore writes
package pch_pkg;
  // Dword byte addresses of the header
  localparam logic [7:0] OFS_ID      = 8'h00;
  localparam logic [7:0] OFS_CMDSTAT = 8'h04;
  localparam logic [7:0] OFS_CLASS   = 8'h08;
  localparam logic [7:0] OFS_LN_LAT  = 8'h0C;
  localparam logic [7:0] OFS_IO_BASE = 8'h10;
  localparam logic [7:0] OFS_MEM_LO  = 8'h14;
  localparam logic [7:0] OFS_MEM_HI  = 8'h18;
  localparam logic [7:0] OFS_RAM_LO  = 8'h1C;
  localparam logic [7:0] OFS_RAM_HI  = 8'h20;
  localparam logic [7:0] OFS_SUBSYS  = 8'h2C;
  localparam logic [7:0] OFS_ROM     = 8'h30;
  localparam logic [7:0] OFS_CAPPTR  = 8'h34;
  localparam logic [7:0] OFS_INTLAT  = 8'h3C;
  localparam logic [7:0] OFS_PWRCAP  = 8'h40;
  // Function numbers
  localparam logic [2:0] FUNC_A      = 3'h0;
  localparam logic [2:0] FUNC_B      = 3'h1;
  // Command bits and writable mask
  localparam int         CMD_IO      = 0;
  localparam int         CMD_MEM     = 1;
  localparam int         CMD_MASTER  = 2;
  localparam int         CMD_INVW    = 4;
  localparam int         CMD_PARITY  = 6;
  localparam int         CMD_SERR    = 8;
  localparam logic [15:0] CMD_MASK   = 16'h0157;
  localparam logic [15:0] CMD_RESET  = 16'h0000;
  // Status bits
  localparam int         ST_PAR_DET  = 15;
  localparam int         ST_SYS_SIG  = 14;
  localparam int         ST_MABORT   = 13;
  localparam int         ST_TABORT   = 12;
  localparam int         ST_MPERR    = 8;
  localparam logic [15:0] ST_STICKY  = 16'hF100;
  localparam logic [15:0] ST_FIXED   = 16'h0210;
  // Fixed values
  localparam logic [23:0] CLASS_CODE = 24'h010000;
  localparam logic [7:0]  HDR_TYPE   = 8'h80;
  localparam logic [7:0]  CAP_PTR    = 8'h40;
  localparam logic [7:0]  PIN_A      = 8'h01;
  localparam logic [7:0]  PIN_B      = 8'h02;
  // Base register read-only low parts
  localparam logic [31:0] IO_LOW_RO  = 32'h000000FF;
  localparam logic [31:0] IO_LOW_FIX = 32'h00000001;
  localparam logic [31:0] MEM_LOW_RO = 32'h000003FF;
  localparam logic [31:0] RAM_LOW_RO = 32'h00001FFF;
  localparam logic [31:0] BARM_FIX   = 32'h00000004;
  localparam logic [31:0] ROM_EN     = 32'h00000001;
endpackage

// *** testbench/pch_header_properties.sv ***
// Port checker for the dual-function configuration header.
// Assumes one clock and the synchronous active-high reset i_rst.
`timescale 1ns/1ns
module pch_header_properties (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // Configuration access
  input wire logic        i_cfg_sel,
  input wire logic        i_cfg_rd,
  input wire logic        i_cfg_wr,
  input wire logic [10:0] i_cfg_addr,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_cfg_ack,
  // Events and enables
  input wire logic [1:0]  i_sys_err_req,
  input wire logic [1:0]  i_addr_parity_err,
  input wire logic [1:0]  o_io_claim_en,
  input wire logic [1:0]  o_mem_claim_en,
  input wire logic [1:0]  o_master_en,
  input wire logic [1:0]  o_parity_check_en,
  input wire logic [1:0]  o_mwi_allowed,
  input wire logic [1:0]  o_perf_cmd_ok,
  input wire logic [1:0]  o_serr_oe,
  input wire logic        o_func_b_on_line_a,
  input wire logic [15:0] o_latency_limit,
  input wire logic [15:0] o_cache_line
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Access taken by function zero or one; higher functions are not ours
  wire logic take = i_cfg_sel & (i_cfg_rd | i_cfg_wr) & (i_cfg_addr[10:9] == 2'b00);
  // Nonzero power of two
  function automatic logic p2(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction
  ack_after_take_a: assert property (take |=> o_cfg_ack)
    else $error("no ack after a taken access");
  ack_needs_take_a: assert property (o_cfg_ack |-> $past(take))
    else $error("ack without a taken access");
  unmapped_zero_a: assert property ($past(take && i_cfg_rd &&
    (i_cfg_addr[7:2] inside {6'h09, 6'h0A})) |-> o_cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  reset_idle_a: assert property ($fell(i_rst) |->
    (o_master_en | o_io_claim_en | o_mem_claim_en) == 2'b00)
    else $error("enables set after reset");
  enables_hold_a: assert property (!$past(i_cfg_wr) |->
    $stable({o_io_claim_en, o_mem_claim_en, o_master_en, o_parity_check_en}))
    else $error("enable moved without a write");
  serr_cause_a: assert property (
    (o_serr_oe & ~$past(i_sys_err_req | i_addr_parity_err)) == 2'b00)
    else $error("error driver without a cause");
  mwi_gate_a: assert property (
    (o_mwi_allowed & ~(o_master_en & o_perf_cmd_ok)) == 2'b00)
    else $error("invalidate writes allowed wrongly");
  perf_pow2_a: assert property (
    o_perf_cmd_ok == {p2(o_cache_line[15:8]), p2(o_cache_line[7:0])})
    else $error("performance commands mismatch line size");
  latency_hold_a: assert property (!$past(i_cfg_wr) |->
    $stable({o_latency_limit, o_cache_line}))
    else $error("timer or line size moved without a write");
  strap_hold_a: assert property ($stable(o_func_b_on_line_a))
    else $error("routing strap copy moved");
endmodule // pch_header_properties
bind pch_config_header pch_header_properties u_props (.i_clk, .i_rst, .i_cfg_sel, .i_cfg_rd,
  .i_cfg_wr, .i_cfg_addr, .o_cfg_rdata, .o_cfg_ack, .i_sys_err_req, .i_addr_parity_err,
  .o_io_claim_en, .o_mem_claim_en, .o_master_en, .o_parity_check_en, .o_mwi_allowed,
  .o_perf_cmd_ok, .o_serr_oe, .o_func_b_on_line_a, .o_latency_limit, .o_cache_line);

// *** testbench/pch_host_model.sv ***
// Host bridge model issuing configuration reads and writes.
// Assumes the header acks one edge after it takes a strobe.
`timescale 1ns/1ns
module pch_host_model (
  // Clock and answer
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  // Configuration request
  output logic             o_sel,
  output logic             o_rd,
  output logic             o_wr,
  output logic [10:0]      o_addr,
  output logic [3:0]       o_be,
  output logic [31:0]      o_wdata
);
  // Idle at time zero
  initial {o_sel, o_rd, o_wr, o_addr, o_be, o_wdata} = '0;
  // One access: strobe pulses once, select and address hold until ack
  task automatic access(input logic w, input logic [10:0] a, input logic [3:0] b,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = '0;
    @(posedge i_clk);
    o_sel <= 1'b1;
    {o_rd, o_wr} <= {!w, w};
    o_addr <= a;
    o_be <= b;
    o_wdata <= d;
    @(posedge i_clk);
    {o_rd, o_wr} <= 2'b00;
    // A refused access never acks, so give up after a few edges
    for (int n = 0; n < 3 && !ok; n++) begin
      @(posedge i_clk);
      ok = (i_ack === 1'b1);
      q = i_rdata;
    end
    // Released lines show the inverse so stale values are not mistaken
    o_sel <= 1'b0;
    o_addr <= ~a;
    o_be <= ~b;
    o_wdata <= ~d;
  endtask
endmodule // pch_host_model

// *** testbench/pci_config_header_dual_function_test.sv ***
// Self-checking bench for the dual-function configuration header.
// Assumes the host model drives the port and the checker is bound.
`timescale 1ns/1ns
module pci_config_header_dual_function_test;
  import pch_pkg::*;
  localparam logic [15:0] MK = 16'h3C96; // Arbitrary maker value
  localparam logic [15:0] PT = 16'h7E21; // Arbitrary part value
  localparam logic [7:0]  RV = 8'h05;    // Arbitrary revision
  localparam logic [7:0]  OFS [3] = '{8'h00, 8'h08, 8'h24}; // Read-only and unmapped places
  localparam logic [7:0]  CLT [4] = '{8'h00, 8'h08, 8'h06, 8'h80}; // Line size corners
  localparam logic [15:0] CMT [4] = '{16'h0000, 16'h0140, 16'h0100, 16'h0040};
  logic        i_clk, i_rst, sel, rd, wr, ack, strap, fb, ok;
  logic [10:0] addr;
  logic [3:0]  be;
  logic [31:0] wd, rdata, q, d;
  logic [1:0]  cti, serr, io, mem, mst, par, mwi, perf;
  logic [1:0]  ev [7];    // Event pulses per function
  logic [15:0] lat, cl, clr, st;
  logic [15:0] sticky [2]; // Expected error flags
  logic [7:0]  c, lat_v, pin;
  logic [6:0]  m;
  logic [2:0]  fn;
  int          miscompares, check_count;
  pch_config_header #(.MAKER_ID(MK), .PART_ID(PT), .REVISION(RV)) uut (
    .i_clk, .i_rst, .i_cfg_sel(sel), .i_cfg_rd(rd), .i_cfg_wr(wr), .i_cfg_addr(addr),
    .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
    .i_int_strap(strap), .i_chip_test_inv_en(cti), .i_data_parity_err(ev[0]),
    .i_addr_parity_err(ev[1]), .i_sys_err_req(ev[2]), .i_master_perr(ev[3]),
    .i_master_abort(ev[4]), .i_special_cycle(ev[5]), .i_target_abort(ev[6]),
    .o_io_claim_en(io), .o_mem_claim_en(mem), .o_master_en(mst), .o_parity_check_en(par),
    .o_mwi_allowed(mwi), .o_perf_cmd_ok(perf), .o_serr_oe(serr),
    .o_func_b_on_line_a(fb), .o_latency_limit(lat), .o_cache_line(cl));
  pch_host_model host (.i_clk, .i_ack(ack), .i_rdata(rdata), .o_sel(sel), .o_rd(rd),
    .o_wr(wr), .o_addr(addr), .o_be(be), .o_wdata(wd));
  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  function automatic logic p2(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd32(input logic [10:0] a);
    host.access(1'b0, a, 4'hF, 32'h0, q, ok);
  endtask
  task automatic wr32(input logic [10:0] a, input logic [3:0] b, input logic [31:0] dat);
    host.access(1'b1, a, b, dat, q, ok);
  endtask
  // One-cycle event pulse; returns just after the edge that samples it
  task automatic pulse(input logic [2:0] f, input logic [6:0] mk);
    @(posedge i_clk);
    for (int k = 0; k < 7; k++) ev[k][f] <= mk[k];
    @(posedge i_clk);
    for (int k = 0; k < 7; k++) ev[k] <= 2'b00;
    #1;
  endtask
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog: the whole sequence needs about 450 cycles
  initial begin
    repeat (8000) @(posedge i_clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h86f98d30));
    i_rst = 1'b1;
    cti = 2'b11;
    strap = 1'($urandom_range(1));
    ev = '{default: 2'b00};
    sticky = '{default: 16'h0000};
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    // Fixed fields of both functions, before and after writes of ones
    for (int p = 0; p < 4; p++) begin
      fn = 3'(p % 2);
      pin = (fn == 3'h0 || strap) ? PIN_A : PIN_B;
      rd32({fn, 8'h00});
      cmp(q, {PT, MK});
      rd32({fn, 8'h04});
      cmp(q, 32'h02100000);
      rd32({fn, 8'h08});
      cmp(q, {CLASS_CODE, RV});
      rd32({fn, 8'h24});
      cmp(q, 32'h0);
      rd32({fn, 8'h3C});
      cmp(q & 32'h0000FF00, {16'h0, pin, 8'h00});
      for (int k = 0; k < 3; k++) wr32({fn, OFS[k]}, 4'hF, 32'hFFFFFFFF);
    end
    cmp(fb, strap);
    // Function two is not ours: no ack, no effect on function zero
    wr32({3'h2, 8'h04}, 4'h3, 32'h0000FFFF);
    cmp(ok, 1'b0);
    rd32({3'h0, 8'h04});
    cmp(q, 32'h02100000);
    // Command enables, line size and timer with random values and corners
    for (int k = 0; k < 12; k++) begin
      fn = 3'($urandom_range(1));
      d = $urandom;
      c = (k < 4) ? CLT[k] : 8'($urandom);
      lat_v = (k == 0) ? 8'hFF : 8'($urandom);
      @(posedge i_clk);
      cti <= 2'($urandom);
      wr32({fn, 8'h04}, 4'h3, d);
      wr32({fn, 8'h0C}, 4'h3, {16'h0, lat_v, c});
      rd32({fn, 8'h04});
      cmp(q, {16'h0210, d[15:0] & CMD_MASK});
      cmp({io[fn], mem[fn], mst[fn], par[fn]}, {d[0], d[1], d[2], d[6]});
      rd32({fn, 8'h0C});
      cmp(q[15:0], {lat_v, c});
      cmp({lat[fn*8 +: 8], cl[fn*8 +: 8], perf[fn]}, {lat_v, c, p2(c)});
      cmp(mwi[fn], p2(c) & d[4] & d[2] & cti[fn]);
    end
    // Error flags set by events and cleared by writing ones
    for (int k = 0; k < 16; k++) begin
      fn = 3'($urandom_range(1));
      d = {16'h0, CMT[k % 4]};
      m = 7'($urandom);
      clr = 16'($urandom);
      wr32({fn, 8'h04}, 4'h3, d);
      pulse(fn, m);
      // Address parity reaches the driver only with both enables
      cmp(serr[fn], d[8] & (m[2] | (m[1] & d[6])));
      st = {m[0], d[8] & (m[2] | (m[1] & d[6])), m[4] & !m[5], m[6], 3'b000, m[3] & d[6], 8'h00};
      sticky[fn] = sticky[fn] | st;
      rd32({fn, 8'h04});
      cmp(q, {sticky[fn] | 16'h0210, d[15:0]});
      wr32({fn, 8'h04}, 4'hC, {clr, 16'h0000});
      sticky[fn] = sticky[fn] & ~clr;
    end
    wrap_up();
  end
endmodule // pci_config_header_dual_function_test
